// ===== bench/sbp_far.sv
// behavioural target agent on the far side of the bus
`timescale 1ns/100ps
module sbp_far #(
  parameter logic [31:0] RD_BASE = 32'hc0de_0000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic respond,
  // wire levels
  input wire logic frameN,
  input wire logic irdyN,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  // driven lines
  output logic tN,
  output logic tOe,
  output logic sN,
  output logic sOe,
  output logic [31:0] aOut,
  output logic aOe,
  output logic pOut,
  output logic pOe,
  // captures
  output logic [31:0] gotAddr,
  output logic [3:0] gotCmd,
  output logic [31:0] gotWord,
  output logic [7:0] beats
);
  logic [1:0] st;
  logic frPrev;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= 2'h0;
      frPrev <= 1'b1;
      tN <= 1'b1;
      tOe <= 1'b0;
      sN <= 1'b1;
      sOe <= 1'b0;
      aOe <= 1'b0;
      pOe <= 1'b0;
      aOut <= RD_BASE;
      pOut <= 1'b0;
    end else begin
      frPrev <= frameN;
      pOut <= ^{aOut, cbe};
      pOe <= aOe;
      case (st)
        2'h0: if (!frameN && frPrev && respond) begin
          gotAddr <= ad;
          gotCmd <= cbe;
          beats <= 8'h00;
          sN <= 1'b0;
          sOe <= 1'b1;
          tOe <= 1'b1;
          st <= 2'h1;
        end
        2'h1: begin
          tN <= 1'b0;
          aOe <= (gotCmd == 4'h6);
          aOut <= RD_BASE;
          st <= 2'h2;
        end
        2'h2: if (!irdyN) begin
          gotWord <= ad;
          beats <= beats + 8'h01;
          aOut <= aOut + 32'h1;
          if (frameN) begin
            tN <= 1'b1;
            sN <= 1'b1;
            aOe <= 1'b0;
            st <= 2'h3;
          end
        end
        // high one cycle before release
        default: begin
          tOe <= 1'b0;
          sOe <= 1'b0;
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the downstream bus port
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic softReset = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [31:0] reqAddr = 32'h0;
  logic [7:0] reqBeats = 8'h01;
  logic [3:0] reqByteEn = 4'h3;
  logic wrValid = 1'b0;
  logic [31:0] wrData = 32'h0;
  logic [31:0] tgtData = 32'h0;
  logic extReq_n = 1'b1;
  logic respond = 1'b1;
  // undriven data, command and parity lines toggle so a stale value never looks valid
  logic [31:0] flt = 32'h5a5a_a5a5;
  logic reqAck, doneValid, doneAbort, wrReady, rdValid, tgtBeat, parErr;
  logic [31:0] rdData, downAddrDataOut, fAd, gotAddr, gotWord;
  logic [3:0] downCmdByteEnOut, gotCmd;
  logic [7:0] beats;
  logic downAddrDataOe, downCmdByteEnOe, downParityOut, downParityOe;
  logic downFrameOut_n, downFrameOe, downInitiatorReadyOut_n;
  logic downInitiatorReadyOe, downTargetReadyOut_n, downTargetReadyOe;
  logic downTargetSelectOut_n, downTargetSelectOe, extGrant_n, downReset_n;
  logic fT, fTOe, fS, fSOe, fAOe, fP, fPOe;
  logic [31:0] pAd;
  logic [3:0] pCbe;
  logic pAOe, pFr, pFrOe, pIr, pIrOe, pTr, pSel;
  logic [31:0] rq[$];
  int checks = 0;
  int miscompares = 0;
  int perrs = 0;
  // the bench itself acts as an initiator when it reads the port as target
  logic [31:0] bAd = 32'h0;
  logic [3:0] bCbe = 4'h0;
  logic bAdOe = 1'b0, bCbeOe = 1'b0, bP = 1'b0, bPOe = 1'b0;
  logic bFr = 1'b1, bIr = 1'b1;
  wire [31:0] downAddrDataIn = downAddrDataOe ? downAddrDataOut
    : fAOe ? fAd : bAdOe ? bAd : flt;
  wire [3:0] downCmdByteEnIn = downCmdByteEnOe ? downCmdByteEnOut
    : bCbeOe ? bCbe : flt[3:0];
  wire downParityIn = downParityOe ? downParityOut
    : fPOe ? fP : bPOe ? bP : flt[0];
  wire downFrameIn_n = downFrameOe ? downFrameOut_n : bFr;
  wire downInitiatorReadyIn_n =
    downInitiatorReadyOe ? downInitiatorReadyOut_n : bIr;
  wire downTargetReadyIn_n =
    downTargetReadyOe ? downTargetReadyOut_n : fTOe ? fT : 1'b1;
  wire downTargetSelectIn_n =
    downTargetSelectOe ? downTargetSelectOut_n : fSOe ? fS : 1'b1;
  sbp_port u_dut (.*);
  sbp_far u_far (.mclk, .reset_n, .respond, .frameN(downFrameIn_n),
    .irdyN(downInitiatorReadyIn_n), .ad(downAddrDataIn),
    .cbe(downCmdByteEnIn), .tN(fT), .tOe(fTOe), .sN(fS), .sOe(fSOe),
    .aOut(fAd), .aOe(fAOe), .pOut(fP), .pOe(fPOe), .gotAddr, .gotCmd,
    .gotWord, .beats);
  always #50 mclk = ~mclk;
  always @(posedge mclk) flt <= ~flt;
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task hang(input string what);
    chk(what, 0, 1);
    tally_and_finish;
  endtask
  task tick;
    @(posedge mclk);
    #1;
  endtask
  // samples the pre-edge values of the wire each clock
  always @(posedge mclk) begin
    if (reset_n) begin
      if (rdValid) rq.push_back(rdData);
      if (parErr) perrs++;
      if (downParityOe) chk("par", ^{pAd, pCbe, downParityIn}, 0);
      chk("parOe", downParityOe, pAOe);
      if (pFrOe && !downFrameOe) chk("fr off", pFr, 1);
      if (pIrOe && !downInitiatorReadyOe) chk("ir off", pIr, 1);
      if (!pIr && pTr && !pSel) chk("ir", downInitiatorReadyIn_n, 0);
      if (!pIr && !pTr) chk("be", pCbe, reqByteEn);
    end
    pAd = downAddrDataIn;
    pCbe = downCmdByteEnIn;
    pAOe = downAddrDataOe;
    pFr = downFrameIn_n;
    pFrOe = downFrameOe;
    pIr = downInitiatorReadyIn_n;
    pIrOe = downInitiatorReadyOe;
    pTr = downTargetReadyIn_n;
    pSel = downTargetSelectIn_n;
  end
  task automatic request(input logic wr, input logic [31:0] a,
    input logic [7:0] n, output int cyc);
    int i;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqBeats = n;
    for (i = 0; i < 60 && reqAck !== 1'b1; i++) tick;
    if (reqAck !== 1'b1) hang("ack");
    reqValid = 1'b0;
    cyc = 0;
    for (i = 0; i < 60 && doneValid !== 1'b1; i++) begin
      tick;
      cyc++;
    end
    if (doneValid !== 1'b1) hang("done");
  endtask
  task automatic push(input logic [31:0] d);
    int i;
    wrValid = 1'b1;
    wrData = d;
    for (i = 0; i < 20 && wrReady !== 1'b1; i++) tick;
    if (wrReady !== 1'b1) hang("fifo");
    tick;
  endtask
  task t_reset;
    chk("rst", downReset_n, 0);
    chk("oe", {downAddrDataOe, downCmdByteEnOe, downParityOe}, 7);
    chk("zero", {downAddrDataOut, downCmdByteEnOut, downParityOut}, 0);
    chk("ctl", {downFrameOe, downInitiatorReadyOe, downTargetReadyOe}, 0);
  endtask
  task t_park;
    chk("rst", downReset_n, 1);
    chk("park", {downAddrDataOe, downCmdByteEnOe, downParityOe}, 7);
  endtask
  // mid-run bus reset and its release
  task t_soft;
    softReset = 1'b1;
    repeat (4) tick;
    t_reset;
    softReset = 1'b0;
    repeat (3) tick;
    t_park;
  endtask
  // one-word read of our window, one wait cycle from the bench initiator
  task automatic t_target;
    int i;
    logic [31:0] a;
    repeat (2) tick;
    a = sbp_pkg::TGT_BASE + 32'h10;
    respond = 1'b0;
    reqByteEn = 4'h1;
    tgtData = 32'h5aa5_0001;
    extReq_n = 1'b0;
    for (i = 0; i < 20 && extGrant_n !== 1'b0; i++) tick;
    if (extGrant_n !== 1'b0) hang("tgnt");
    repeat (2) tick;
    bFr = 1'b0;
    bAd = a;
    bAdOe = 1'b1;
    bCbe = sbp_pkg::CMD_MEM_READ;
    bCbeOe = 1'b1;
    tick;
    bAdOe = 1'b0;
    bCbe = reqByteEn;
    bP = ^{a, sbp_pkg::CMD_MEM_READ};
    bPOe = 1'b1;
    tick;
    bPOe = 1'b0;
    chk("tsel", downTargetSelectIn_n, 0);
    chk("tdat", downAddrDataIn, tgtData);
    tick;
    chk("twait", downTargetReadyIn_n, 0);
    bFr = 1'b1;
    bIr = 1'b0;
    tick;
    chk("tbeat", tgtBeat, 1);
    bIr = 1'b1;
    bCbeOe = 1'b0;
    repeat (2) tick;
    chk("tperr", perrs, 0);
    chk("trel", {downAddrDataOe, downTargetReadyOe}, 0);
    extReq_n = 1'b1;
    respond = 1'b1;
  endtask
  task automatic t_write;
    int i, c;
    for (i = 0; i < 4; i++) push(32'h1234_0000 + i);
    wrValid = 1'b0;
    chk("full", wrReady, 0);
    request(1'b1, 32'h4000_0100, 8'h04, c);
    chk("cmd", gotCmd, sbp_pkg::CMD_MEM_WRITE);
    chk("addr", gotAddr, 32'h4000_0100);
    chk("beats", beats, 4);
    chk("word", gotWord, 32'h1234_0003);
    chk("abort", doneAbort, 0);
    chk("free", wrReady, 1);
  endtask
  task automatic t_read;
    int c;
    request(1'b0, 32'h4000_0200, 8'h02, c);
    repeat (2) tick;
    chk("cmd", gotCmd, sbp_pkg::CMD_MEM_READ);
    chk("words", rq.size(), 2);
    chk("w0", rq[0], 32'hc0de_0000);
    chk("w1", rq[1], 32'hc0de_0001);
    chk("perr", perrs, 0);
  endtask
  task automatic t_abort;
    int c;
    respond = 1'b0;
    request(1'b0, 32'h4000_0300, 8'h01, c);
    chk("abort", doneAbort, 1);
    chk("atime", c >= 5 && c <= 8, 1);
    respond = 1'b1;
  endtask
  task automatic t_grant;
    int i, gap;
    extReq_n = 1'b0;
    for (i = 0; i < 20 && extGrant_n !== 1'b0; i++) tick;
    chk("gnt", extGrant_n, 0);
    extReq_n = 1'b1;
    for (i = 0; i < 20 && extGrant_n !== 1'b1; i++) tick;
    extReq_n = 1'b0;
    gap = 0;
    for (i = 0; i < 20 && extGrant_n !== 1'b0; i++) begin
      tick;
      gap++;
    end
    chk("gap", gap >= 2 && extGrant_n === 1'b0, 1);
    extReq_n = 1'b1;
  endtask
  initial begin
    repeat (3) tick;
    t_reset;
    tick;
    reset_n = 1'b1;
    repeat (4) tick;
    t_park;
    t_soft;
    t_write;
    t_read;
    t_abort;
    repeat (3) tick;
    t_grant;
    t_target;
    tally_and_finish;
  end
endmodule

// ===== hw/sbp_arb.sv
// grant logic for one external requester, internal side parks
`timescale 1ns/100ps
module sbp_arb (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // requests and bus state
  input wire logic extReq_n,
  input wire logic busIdle,
  input wire logic intWant,
  // grants
  output logic extGrant_n,
  output logic intGrant
);
  logic [1:0] gap;

  wire gapDone = (gap == sbp_pkg::GAP_ZERO);
  wire extOn = !extGrant_n;
  wire giveExt = !extOn && gapDone && !extReq_n && busIdle && !intWant;
  wire dropExt = extOn && (extReq_n || (intWant && busIdle));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extGrant_n <= 1'b1;
      intGrant <= 1'b1;
      gap <= sbp_pkg::GAP_ZERO;
    end else if (ce) begin
      if (dropExt) extGrant_n <= 1'b1;
      else if (giveExt) extGrant_n <= 1'b0;
      // gap counts the idle clocks still owed before a new grant
      if (dropExt) gap <= sbp_pkg::GRANT_GAP - sbp_pkg::GAP_ONE;
      else if (!gapDone) gap <= gap - sbp_pkg::GAP_ONE;
      intGrant <= !giveExt && (dropExt || extGrant_n);
    end
  end

  property p_grant_gap;
    @(posedge mclk) disable iff (!reset_n)
    $rose(extGrant_n) |-> extGrant_n [*2];
  endproperty
  a_grant_gap: assert property (p_grant_gap)
    else $error("external grant reasserted too soon");
endmodule

// ===== hw/sbp_fifo.sv
// small write-data fifo with registered full flag
`timescale 1ns/100ps
module sbp_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // streams
  sbp_stream_if.snk inS,
  sbp_stream_if.src outS
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic notFull;

  wire push = inS.valid & notFull;
  wire pop = outS.valid & outS.ready;
  wire [CW-1:0] next_count = count + (push ? CNT_ONE : '0)
                             - (pop ? CNT_ONE : '0);

  assign inS.ready = notFull;
  assign outS.valid = (count != '0);
  assign outS.data = mem[rdPtr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_IDX) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem[wrPtr] <= inS.data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      notFull <= 1'b1;
    end else if (ce) begin
      if (push) wrPtr <= bump(wrPtr);
      if (pop) rdPtr <= bump(rdPtr);
      count <= next_count;
      notFull <= (next_count != FULL_CNT);
    end
  end
endmodule

// ===== hw/sbp_port.sv
// downstream bus port: initiator, read target, parking and reset drive
`timescale 1ns/100ps
module sbp_port #(
  parameter int BEAT_W = sbp_pkg::BEAT_W,
  parameter int FIFO_DEPTH = sbp_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic softReset,
  // initiator request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic [BEAT_W-1:0] reqBeats,
  input wire logic [3:0] reqByteEn,
  output logic reqAck,
  output logic doneValid,
  output logic doneAbort,
  // write data in, read data out
  input wire logic wrValid,
  input wire logic [31:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [31:0] rdData,
  // target read data
  input wire logic [31:0] tgtData,
  output logic tgtBeat,
  output logic parErr,
  // bus pins
  input wire logic [31:0] downAddrDataIn,
  output logic [31:0] downAddrDataOut,
  output logic downAddrDataOe,
  input wire logic [3:0] downCmdByteEnIn,
  output logic [3:0] downCmdByteEnOut,
  output logic downCmdByteEnOe,
  input wire logic downParityIn,
  output logic downParityOut,
  output logic downParityOe,
  input wire logic downFrameIn_n,
  output logic downFrameOut_n,
  output logic downFrameOe,
  input wire logic downInitiatorReadyIn_n,
  output logic downInitiatorReadyOut_n,
  output logic downInitiatorReadyOe,
  input wire logic downTargetReadyIn_n,
  output logic downTargetReadyOut_n,
  output logic downTargetReadyOe,
  input wire logic downTargetSelectIn_n,
  output logic downTargetSelectOut_n,
  output logic downTargetSelectOe,
  // arbitration and reset out
  input wire logic extReq_n,
  output logic extGrant_n,
  output logic downReset_n
);
  sbp_pkg::sbp_init_t stI, next_stI;
  sbp_pkg::sbp_tgt_t stT, next_stT;
  logic isWr;
  logic [3:0] byteEn;
  logic [BEAT_W-1:0] beats;
  logic [2:0] devCnt;
  logic sawDev;
  logic frameInPrev;
  logic chkPend;
  logic chkSum;
  logic intGrant;

  sbp_stream_if #(.W(sbp_pkg::AD_W)) wrIn ();
  sbp_stream_if #(.W(sbp_pkg::AD_W)) wrOut ();

  assign wrIn.valid = wrValid;
  assign wrIn.data = wrData;
  assign wrReady = wrIn.ready;

  sbp_fifo #(.W(sbp_pkg::AD_W), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .inS(wrIn),
    .outS(wrOut)
  );

  // bus state seen on the pins
  wire busIdle = downFrameIn_n & downInitiatorReadyIn_n;
  wire rstOut = !downReset_n;
  wire frameLow = downFrameOe && !downFrameOut_n;
  wire irdyLow = (stI == sbp_pkg::I_DATA) && !downInitiatorReadyOut_n;
  wire lastBeat = (beats == sbp_pkg::BEAT_ONE);
  wire canData = !isWr || wrOut.valid;
  wire intWant = reqValid || (stI != sbp_pkg::I_IDLE);
  wire allIdle = (stI == sbp_pkg::I_IDLE) && (stT == sbp_pkg::T_IDLE);

  // initiator decode
  wire startI = allIdle && intGrant && busIdle && reqValid && !rstOut;
  wire xferI = irdyLow && !downTargetReadyIn_n;
  wire timeout = (stI == sbp_pkg::I_DATA) && !sawDev
                 && downTargetSelectIn_n
                 && (devCnt == sbp_pkg::DEVSEL_WAIT);
  wire irdyOn = ((stI == sbp_pkg::I_ADDR)
                || ((stI == sbp_pkg::I_DATA) && downInitiatorReadyOut_n))
                && canData && !timeout;
  wire next_irdyLow = irdyOn || (irdyLow && !xferI && !timeout);
  wire endI = (xferI && lastBeat) || timeout;
  wire loadW = isWr && irdyOn;
  wire park = allIdle && intGrant && busIdle && !startI;

  // target decode: memory read into our window
  wire hit = (downAddrDataIn[31:sbp_pkg::TGT_WIN_W]
             == sbp_pkg::TGT_BASE[31:sbp_pkg::TGT_WIN_W]);
  wire claim = allIdle && !rstOut && frameInPrev && !downFrameIn_n
               && hit && (downCmdByteEnIn == sbp_pkg::CMD_MEM_READ);
  wire xferT = (stT == sbp_pkg::T_DATA) && !downTargetReadyOut_n
               && !downInitiatorReadyIn_n;
  wire endT = xferT && downFrameIn_n;
  wire tgtDrive = claim || (stT == sbp_pkg::T_WAIT)
                  || (stT == sbp_pkg::T_DATA);

  // next pin values
  wire initAd = startI || (isWr && ((stI == sbp_pkg::I_ADDR)
                || ((stI == sbp_pkg::I_DATA) && !endI)));
  wire tgtAd = (stT == sbp_pkg::T_WAIT)
               || ((stT == sbp_pkg::T_DATA) && !endT);
  wire next_adOe = rstOut || initAd || tgtAd || park;
  wire initOn = (stI == sbp_pkg::I_ADDR) || (stI == sbp_pkg::I_DATA);
  wire next_cbeOe = rstOut || startI || park
                    || (stI == sbp_pkg::I_ADDR)
                    || ((stI == sbp_pkg::I_DATA) && !endI);
  wire [31:0] next_ad = rstOut ? sbp_pkg::AD_ZERO
                      : startI ? reqAddr
                      : loadW ? wrOut.data
                      : (stT == sbp_pkg::T_WAIT) ? tgtData
                      : downAddrDataOut;
  wire [3:0] next_cbe = rstOut ? sbp_pkg::CBE_ZERO
                      : startI ? (reqWrite ? sbp_pkg::CMD_MEM_WRITE
                                           : sbp_pkg::CMD_MEM_READ)
                      : (stI == sbp_pkg::I_ADDR) ? byteEn
                      : downCmdByteEnOut;
  wire next_frameLow = !rstOut && (startI || (frameLow
                       && !(next_irdyLow && lastBeat) && !timeout));
  wire next_trdyLow = (stT == sbp_pkg::T_WAIT)
                      || ((stT == sbp_pkg::T_DATA) && !xferT);
  wire next_selLow = claim || (stT == sbp_pkg::T_WAIT)
                     || ((stT == sbp_pkg::T_DATA) && !endT);

  always_comb begin
    next_stI = stI;
    unique case (stI)
      sbp_pkg::I_IDLE: if (startI) next_stI = sbp_pkg::I_ADDR;
      sbp_pkg::I_ADDR: next_stI = sbp_pkg::I_DATA;
      sbp_pkg::I_DATA: if (endI) next_stI = sbp_pkg::I_TURN;
      sbp_pkg::I_TURN: next_stI = sbp_pkg::I_IDLE;
    endcase
    if (rstOut) next_stI = sbp_pkg::I_IDLE;
  end

  always_comb begin
    next_stT = stT;
    unique case (stT)
      sbp_pkg::T_IDLE: if (claim) next_stT = sbp_pkg::T_WAIT;
      sbp_pkg::T_WAIT: next_stT = sbp_pkg::T_DATA;
      sbp_pkg::T_DATA: begin
        if (endT) next_stT = sbp_pkg::T_TURN;
        else if (xferT) next_stT = sbp_pkg::T_WAIT;
      end
      sbp_pkg::T_TURN: next_stT = sbp_pkg::T_IDLE;
    endcase
    if (rstOut) next_stT = sbp_pkg::T_IDLE;
  end

  assign wrOut.ready = xferI && isWr;

  sbp_arb u_arb (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .extReq_n(extReq_n),
    .busIdle(busIdle),
    .intWant(intWant),
    .extGrant_n(extGrant_n),
    .intGrant(intGrant)
  );

  // states and transaction bookkeeping
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stI <= sbp_pkg::I_IDLE;
      stT <= sbp_pkg::T_IDLE;
      isWr <= 1'b0;
      byteEn <= sbp_pkg::CBE_ZERO;
      beats <= '0;
      frameInPrev <= 1'b1;
      downReset_n <= 1'b0;
    end else if (ce) begin
      stI <= next_stI;
      stT <= next_stT;
      frameInPrev <= downFrameIn_n;
      downReset_n <= !softReset;
      if (startI) begin
        isWr <= reqWrite;
        byteEn <= reqByteEn;
        beats <= reqBeats;
      end else if (xferI) begin
        beats <= beats - sbp_pkg::BEAT_ONE;
      end
    end
  end

  // select watchdog runs from the frame edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      devCnt <= sbp_pkg::DEVSEL_ZERO;
      sawDev <= 1'b0;
    end else if (ce) begin
      if (startI) begin
        devCnt <= sbp_pkg::DEVSEL_ZERO;
        sawDev <= 1'b0;
      end else if (initOn) begin
        if (devCnt != sbp_pkg::DEVSEL_WAIT)
          devCnt <= devCnt + sbp_pkg::DEVSEL_ONE;
        sawDev <= sawDev | !downTargetSelectIn_n;
      end
    end
  end

  // pins; reset values match the reset-out drive
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      downAddrDataOut <= sbp_pkg::AD_ZERO;
      downAddrDataOe <= 1'b1;
      downCmdByteEnOut <= sbp_pkg::CBE_ZERO;
      downCmdByteEnOe <= 1'b1;
      downParityOut <= 1'b0;
      downParityOe <= 1'b1;
      downFrameOut_n <= 1'b1;
      downFrameOe <= 1'b0;
      downInitiatorReadyOut_n <= 1'b1;
      downInitiatorReadyOe <= 1'b0;
      downTargetReadyOut_n <= 1'b1;
      downTargetReadyOe <= 1'b0;
      downTargetSelectOut_n <= 1'b1;
      downTargetSelectOe <= 1'b0;
    end else if (ce) begin
      downAddrDataOut <= next_ad;
      downAddrDataOe <= next_adOe;
      downCmdByteEnOut <= next_cbe;
      downCmdByteEnOe <= next_cbeOe;
      // parity trails its word by one clock, and so does its release
      // command lines are read back from the bus: as a read target the
      // initiator owns them while we own the data lines
      downParityOut <= ^{downAddrDataOut, downCmdByteEnIn};
      downParityOe <= downAddrDataOe;
      downFrameOut_n <= !next_frameLow;
      downFrameOe <= !rstOut && (startI || initOn);
      downInitiatorReadyOut_n <= !next_irdyLow;
      downInitiatorReadyOe <= !rstOut && initOn;
      downTargetReadyOut_n <= !next_trdyLow;
      downTargetReadyOe <= !rstOut && tgtDrive;
      downTargetSelectOut_n <= !next_selLow;
      downTargetSelectOe <= !rstOut && tgtDrive;
    end
  end

  // user side results and parity check of received words
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reqAck <= 1'b0;
      doneValid <= 1'b0;
      doneAbort <= 1'b0;
      rdValid <= 1'b0;
      rdData <= sbp_pkg::AD_ZERO;
      tgtBeat <= 1'b0;
      chkPend <= 1'b0;
      chkSum <= 1'b0;
      parErr <= 1'b0;
    end else if (ce) begin
      reqAck <= startI;
      doneValid <= (stI == sbp_pkg::I_DATA) && endI;
      doneAbort <= timeout;
      rdValid <= xferI && !isWr;
      if (xferI && !isWr) rdData <= downAddrDataIn;
      tgtBeat <= xferT;
      // parity of a read word or a claimed address comes a clock later
      chkPend <= (xferI && !isWr) || claim;
      chkSum <= ^{downAddrDataIn, downCmdByteEnIn};
      parErr <= chkPend && (chkSum != downParityIn);
    end
  end

  property p_addr_phase;
    @(posedge mclk) disable iff (!reset_n || !ce)
    (stI == sbp_pkg::I_ADDR) |-> downAddrDataOe && !downFrameOut_n
      && downFrameOe && downAddrDataOut == $past(reqAddr)
      && downCmdByteEnOut == (isWr ? sbp_pkg::CMD_MEM_WRITE
                                   : sbp_pkg::CMD_MEM_READ);
  endproperty
  a_addr_phase: assert property (p_addr_phase)
    else $error("address phase not driven with frame");

  property p_read_capture;
    @(posedge mclk) disable iff (!reset_n || !ce)
    (xferI && !isWr) |=> rdValid && rdData == $past(downAddrDataIn);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("read word not captured on transfer");

  property p_write_stable;
    @(posedge mclk) disable iff (!reset_n || !ce)
    (irdyLow && isWr && downTargetReadyIn_n && !timeout)
      |=> $stable(downAddrDataOut) && !downInitiatorReadyOut_n;
  endproperty
  a_write_stable: assert property (p_write_stable)
    else $error("write data or ready moved in a wait state");

  property p_park;
    @(posedge mclk) disable iff (!reset_n || !ce)
    park ##1 ce |-> downAddrDataOe && downCmdByteEnOe ##1 downParityOe;
  endproperty
  a_park: assert property (p_park)
    else $error("parked bus left floating");

  property p_byte_en;
    @(posedge mclk) disable iff (!reset_n || !ce)
    (stI == sbp_pkg::I_DATA && downCmdByteEnOe) |-> downCmdByteEnOut == byteEn;
  endproperty
  a_byte_en: assert property (p_byte_en)
    else $error("byte enables wrong in data phase");

  property p_parity;
    @(posedge mclk) disable iff (!reset_n || !ce)
    ($past(ce) && downParityOe) |-> downParityOut
      == ^{$past(downAddrDataOut), $past(downCmdByteEnIn)};
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity not even over the previous word");

  property p_par_release;
    @(posedge mclk) disable iff (!reset_n || !ce)
    $fell(downAddrDataOe) |-> downParityOe ##1 !downParityOe;
  endproperty
  a_par_release: assert property (p_par_release)
    else $error("parity not released one clock after data lines");

  property p_frame_last;
    @(posedge mclk) disable iff (!reset_n || !ce)
    ($rose(downFrameOut_n) && downFrameOe && !rstOut && !doneAbort
      && !$past(timeout)) |-> !downInitiatorReadyOut_n;
  endproperty
  a_frame_last: assert property (p_frame_last)
    else $error("frame released without final ready");

  property p_release_high;
    @(posedge mclk) disable iff (!reset_n || !ce || rstOut)
    ($fell(downInitiatorReadyOe) |-> $past(downInitiatorReadyOut_n))
      and ($fell(downTargetReadyOe) |-> $past(downTargetReadyOut_n))
      and ($fell(downFrameOe) |-> $past(downFrameOut_n));
  endproperty
  a_release_high: assert property (p_release_high)
    else $error("control released while asserted");

  property p_trdy_hold;
    @(posedge mclk) disable iff (!reset_n || !ce || rstOut)
    (stT == sbp_pkg::T_DATA && !xferT) |=> !downTargetReadyOut_n;
  endproperty
  a_trdy_hold: assert property (p_trdy_hold)
    else $error("target ready dropped inside a data phase");

  property p_abort;
    @(posedge mclk) disable iff (!reset_n || !ce)
    timeout |=> stI == sbp_pkg::I_TURN && doneAbort && doneValid
      && downFrameOut_n && downInitiatorReadyOut_n;
  endproperty
  a_abort: assert property (p_abort)
    else $error("master abort not taken");

  property p_reset_drive;
    @(posedge mclk) disable iff (!reset_n)
    (rstOut && $past(rstOut) && $past(rstOut, 2)) |->
      !downFrameOe && !downInitiatorReadyOe && !downTargetReadyOe
      && downAddrDataOut == sbp_pkg::AD_ZERO && !downParityOut
      && downCmdByteEnOut == sbp_pkg::CBE_ZERO && downParityOe;
  endproperty
  a_reset_drive: assert property (p_reset_drive)
    else $error("reset out drive wrong");
endmodule

// ===== pkg/sbp_pkg.sv
// constants and types of the downstream bus port
package sbp_pkg;
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int BEAT_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  // clock period and the master abort window
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEVSEL_WAIT_CYC = 5;
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;
  localparam logic [2:0] DEVSEL_ZERO = 3'h0;
  localparam logic [2:0] DEVSEL_ONE = 3'h1;
  // least idle time of the external grant, in bus clocks
  localparam logic [1:0] GRANT_GAP = 2'h2;
  localparam logic [1:0] GAP_ONE = 2'h1;
  localparam logic [1:0] GAP_ZERO = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 8'h01;
  localparam logic [AD_W-1:0] AD_ZERO = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_ZERO = 4'h0;
  localparam int TGT_WIN_W = 12;
  localparam logic [AD_W-1:0] TGT_BASE = 32'h0001_0000;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_DATA = 2'b11,
    I_TURN = 2'b10
  } sbp_init_t;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_DATA = 2'b11,
    T_TURN = 2'b10
  } sbp_tgt_t;
endpackage

// ===== pkg/sbp_stream_if.sv
// valid/ready word stream between the port's own modules
`timescale 1ns/100ps
interface sbp_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
